// File: rtl/psc_params.svh
// Offsets, keys, encodings and reset values for the parameter store control
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// Object indices
`define PSC_IDX_STORE 16'h1010
`define PSC_IDX_DISCARD 16'h1011
`define PSC_IDX_MARKER 16'h1020
`define PSC_IDX_REBOOT 16'h2800

// Key values, ASCII "save", "load", "boot"
`define PSC_KEY_SAVE 32'h6576_6173
`define PSC_KEY_DISCARD 32'h6461_6f6c
`define PSC_KEY_REBOOT 32'h746f_6f62

// Command subindices
`define PSC_SUB_COUNT 8'h00
`define PSC_SUB_ALL 8'h01
`define PSC_SUB_COMM 8'h02
`define PSC_SUB_APP 8'h03
`define PSC_SUB_USER 8'h04
`define PSC_SUB_MOVE 8'h05
`define PSC_SUB_TUNE 8'h06
`define PSC_SUB_ETH 8'h0c
`define PSC_SUB_REBOOT 8'h01
`define PSC_SUB_MK_DATE 8'h01
`define PSC_SUB_MK_TIME 8'h02
`define PSC_MK_COUNT 32'h0000_0002

// Category mask bit positions
`define PSC_CAT_COMM 0
`define PSC_CAT_APP 1
`define PSC_CAT_USER 2
`define PSC_CAT_MOVE 3
`define PSC_CAT_TUNE 4
`define PSC_CAT_ETH 5
`define PSC_CAT_MARK 6

// Reset and completion values
`define PSC_CMD_RST 32'h0000_0001
`define PSC_CMD_DONE 32'h0000_0001
`define PSC_MK_RST 32'h0000_0000

`endif

// File: rtl/psc_pkg.sv
// Types and helpers shared by the parameter store control modules
`default_nettype none
`include "psc_params.svh"
package psc_pkg;
  typedef enum logic [1:0] {PSC_OP_SAVE, PSC_OP_DISCARD, PSC_OP_LOAD} psc_op_t;
  typedef logic [6:0] psc_mask_t;
  typedef logic [2:0] psc_slot_t;

  localparam psc_slot_t PSC_SLOT_NONE = 3'h7;

  // Command subindex to entry slot; unknown subindices give PSC_SLOT_NONE
  function automatic psc_slot_t psc_slot(input logic [7:0] sub);
    psc_slot_t s;
    s = PSC_SLOT_NONE;
    if (sub == `PSC_SUB_ALL) s = 3'h0;
    else if (sub == `PSC_SUB_COMM) s = 3'h1;
    else if (sub == `PSC_SUB_APP) s = 3'h2;
    else if (sub == `PSC_SUB_USER) s = 3'h3;
    else if (sub == `PSC_SUB_MOVE) s = 3'h4;
    else if (sub == `PSC_SUB_TUNE) s = 3'h5;
    else if (sub == `PSC_SUB_ETH) s = 3'h6;
    return s;
  endfunction : psc_slot
endpackage : psc_pkg
`default_nettype wire

// File: rtl/psc_nv_if.sv
// Command and status carrier between the store controller and its memory engine
`default_nettype none
interface psc_nv_if;
  import psc_pkg::*;
  logic start;
  psc_op_t op;
  psc_mask_t mask;
  logic [31:0] mk_date;
  logic [31:0] mk_time;
  logic busy;
  logic done;
  logic ld_valid;
  logic [31:0] ld_date;
  logic [31:0] ld_time;
  modport ctrl (output start, op, mask, mk_date, mk_time, input busy, done, ld_valid, ld_date, ld_time);
  modport eng (input start, op, mask, mk_date, mk_time, output busy, done, ld_valid, ld_date, ld_time);
endinterface : psc_nv_if
`default_nettype wire

// File: rtl/psc_nv_engine.sv
// Sequencer that drives whole-category operations on the nonvolatile store
`default_nettype none
`include "psc_params.svh"
module psc_nv_engine (
  input wire logic clk,                    // System clock
  input wire logic rst_n,                  // Asynchronous reset, active low
  psc_nv_if.eng cmd,                       // Commands from the controller
  output logic nv_req_q,                   // Operation request, held until ack
  output psc_pkg::psc_op_t nv_op_q,        // Operation kind
  output psc_pkg::psc_mask_t nv_mask_q,    // Categories involved
  output logic [31:0] nv_wdate_q,          // Marker date to save
  output logic [31:0] nv_wtime_q,          // Marker time to save
  input wire logic nv_ack,                 // Memory finished, one-cycle pulse
  input wire logic [31:0] nv_rdate,        // Loaded marker date, valid with ack
  input wire logic [31:0] nv_rtime         // Loaded marker time, valid with ack
);
  import psc_pkg::*;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_WAIT} psc_eng_st_t;
  psc_eng_st_t state_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_BOOT;
      nv_req_q <= 1'b0;
      nv_op_q <= PSC_OP_LOAD;
      nv_mask_q <= '0;
      nv_wdate_q <= '0;
      nv_wtime_q <= '0;
      cmd.busy <= 1'b1;
      cmd.done <= 1'b0;
      cmd.ld_valid <= 1'b0;
      cmd.ld_date <= '0;
      cmd.ld_time <= '0;
    end else begin
      cmd.done <= 1'b0;
      cmd.ld_valid <= 1'b0;
      case (state_q)
        ST_BOOT: begin
          nv_req_q <= 1'b1;
          nv_op_q <= PSC_OP_LOAD;
          nv_mask_q <= '1;
          state_q <= ST_WAIT;
        end
        ST_IDLE: begin
          if (cmd.start) begin
            nv_req_q <= 1'b1;
            nv_op_q <= cmd.op;
            nv_mask_q <= cmd.mask;
            // Marker snapshot is taken at start so later writes cannot tear it
            nv_wdate_q <= cmd.mk_date;
            nv_wtime_q <= cmd.mk_time;
            cmd.busy <= 1'b1;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (nv_ack) begin
            nv_req_q <= 1'b0;
            cmd.busy <= 1'b0;
            cmd.done <= 1'b1;
            if (nv_op_q == PSC_OP_LOAD) begin
              cmd.ld_valid <= 1'b1;
              cmd.ld_date <= nv_rdate;
              cmd.ld_time <= nv_rtime;
            end
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule : psc_nv_engine
`default_nettype wire

// File: rtl/psc_top.sv
// Parameter store control: save, discard, reboot and configuration marker objects
// Contract
// - Save key written to a store subindex starts saving that category.
// - On save completion the triggering store entry reads back one.
// - Subindex 01 all but Ethernet, 02..06 single categories, 0C Ethernet.
// - Discard key written to a discard subindex deletes that category's saved data.
// - Discard at 01 clears all saved categories except tuning, Ethernet and the marker.
// - Discard leaves active values untouched until the next restart.
// - Reboot key written to reboot object subindex 01 restarts the controller.
// - Tuning saved data is cleared only by discard at subindex 06.
// - Drive category holds submode, inertia, loop parameters, current and speed limits.
// - Tuning category holds poles, currents, I2t, encoder, feedback and ballast objects.
// - Marker entries hold date and time and are saved by save-all.
// - Writes to savable objects clear the marker, except save-all and marker writes.
// - Saving acts on whole categories only, never single objects.
// - Saved values reload automatically at power-on or reset.
// - Objects without a category are never saved.
`default_nettype none
`include "psc_params.svh"
module psc_top (
  input wire logic clk,                    // System clock, 250 MHz
  input wire logic rst_n,                  // Asynchronous reset, active low
  input wire logic od_wr,                  // Object write strobe, one cycle
  input wire logic od_rd,                  // Object read strobe, one cycle
  input wire logic [15:0] od_index,        // Object index
  input wire logic [7:0] od_sub,           // Object subindex
  input wire logic [31:0] od_wdata,        // Write value
  input wire logic od_savable,             // Written object has a category
  output logic [31:0] od_rdata_q,          // Read value
  output logic od_rvalid_q,                // Read answer, one cycle
  output logic od_err_q,                   // Unmapped read or refused write, one cycle
  output logic busy_q,                     // Store operation in progress
  output logic restart_q,                  // Controller restart request, one cycle
  output logic nv_req_q,                   // Memory operation request
  output psc_pkg::psc_op_t nv_op_q,        // Memory operation kind
  output psc_pkg::psc_mask_t nv_mask_q,    // Categories involved
  output logic [31:0] nv_wdate_q,          // Marker date to save
  output logic [31:0] nv_wtime_q,          // Marker time to save
  input wire logic nv_ack,                 // Memory done, one cycle
  input wire logic [31:0] nv_rdate,        // Loaded marker date
  input wire logic [31:0] nv_rtime         // Loaded marker time
);
  import psc_pkg::*;

  psc_nv_if nv ();

  psc_nv_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .cmd(nv),
    .nv_req_q(nv_req_q),
    .nv_op_q(nv_op_q),
    .nv_mask_q(nv_mask_q),
    .nv_wdate_q(nv_wdate_q),
    .nv_wtime_q(nv_wtime_q),
    .nv_ack(nv_ack),
    .nv_rdate(nv_rdate),
    .nv_rtime(nv_rtime)
  );

  logic [31:0] store_q [7];
  logic [31:0] discard_q [7];
  logic [31:0] mk_date_q;
  logic [31:0] mk_time_q;
  psc_slot_t last_slot_q;
  logic last_save_q;
  logic start_q;
  psc_op_t op_q;
  psc_mask_t mask_q;

  psc_slot_t wr_slot;
  logic wr_store;
  logic wr_discard;
  logic save_go;
  logic discard_go;
  psc_mask_t save_mask;
  psc_mask_t discard_mask;

  always_comb begin
    wr_slot = psc_slot(od_sub);
    wr_store = od_wr && od_index == `PSC_IDX_STORE && wr_slot != PSC_SLOT_NONE;
    wr_discard = od_wr && od_index == `PSC_IDX_DISCARD && wr_slot != PSC_SLOT_NONE;
    save_go = wr_store && !nv.busy && !start_q && od_wdata == `PSC_KEY_SAVE;
    discard_go = wr_discard && !nv.busy && !start_q && od_wdata == `PSC_KEY_DISCARD;
    save_mask = '0;
    discard_mask = '0;
    case (wr_slot)
      3'h0: begin
        save_mask = '1;
        save_mask[`PSC_CAT_ETH] = 1'b0;
        discard_mask = '1;
        discard_mask[`PSC_CAT_ETH] = 1'b0;
        discard_mask[`PSC_CAT_TUNE] = 1'b0;
        discard_mask[`PSC_CAT_MARK] = 1'b0;
      end
      3'h1: save_mask[`PSC_CAT_COMM] = 1'b1;
      3'h2: save_mask[`PSC_CAT_APP] = 1'b1;
      3'h3: save_mask[`PSC_CAT_USER] = 1'b1;
      3'h4: save_mask[`PSC_CAT_MOVE] = 1'b1;
      3'h5: save_mask[`PSC_CAT_TUNE] = 1'b1;
      3'h6: save_mask[`PSC_CAT_ETH] = 1'b1;
      default: save_mask = '0;
    endcase
    // tuning only through its own subindex
    if (wr_slot != 3'h0) begin
      discard_mask = save_mask;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      op_q <= PSC_OP_SAVE;
      mask_q <= '0;
      last_slot_q <= '0;
      last_save_q <= 1'b0;
    end else begin
      start_q <= save_go || discard_go;
      if (save_go || discard_go) begin
        op_q <= save_go ? PSC_OP_SAVE : PSC_OP_DISCARD;
        // uncategorised objects have no mask bit
        mask_q <= save_go ? save_mask : discard_mask;
        last_slot_q <= wr_slot;
        last_save_q <= save_go;
      end
    end
  end

  assign nv.start = start_q;
  assign nv.op = op_q;
  assign nv.mask = mask_q;
  assign nv.mk_date = mk_date_q;
  assign nv.mk_time = mk_time_q;

  // Command entries hold the key while running and read one when finished
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          store_q[g] <= `PSC_CMD_RST;
          discard_q[g] <= `PSC_CMD_RST;
        end else if (nv.done && last_slot_q == psc_slot_t'(g) && !start_q) begin
          if (last_save_q) store_q[g] <= `PSC_CMD_DONE;
          else discard_q[g] <= `PSC_CMD_DONE;
        end else if (save_go && wr_slot == psc_slot_t'(g)) begin
          store_q[g] <= od_wdata;
        end else if (discard_go && wr_slot == psc_slot_t'(g)) begin
          // discard acts on saved data only
          discard_q[g] <= od_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mk_date_q <= `PSC_MK_RST;
      mk_time_q <= `PSC_MK_RST;
    end else if (nv.ld_valid) begin
      mk_date_q <= nv.ld_date;
      mk_time_q <= nv.ld_time;
    end else if (od_wr && od_index == `PSC_IDX_MARKER) begin
      if (od_sub == `PSC_SUB_MK_DATE) mk_date_q <= od_wdata;
      if (od_sub == `PSC_SUB_MK_TIME) mk_time_q <= od_wdata;
    end else if (od_wr && (od_savable || (od_index == `PSC_IDX_STORE && od_sub != `PSC_SUB_ALL))) begin
      mk_date_q <= `PSC_MK_RST;
      mk_time_q <= `PSC_MK_RST;
    end
  end

  // reboot key; discarded defaults apply through this restart or through the reload after a reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= od_wr && od_index == `PSC_IDX_REBOOT && od_sub == `PSC_SUB_REBOOT && od_wdata == `PSC_KEY_REBOOT;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b1;
    end else begin
      busy_q <= nv.busy || start_q;
    end
  end

  // Read answers one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      od_rdata_q <= '0;
      od_rvalid_q <= 1'b0;
      od_err_q <= 1'b0;
    end else begin
      od_rvalid_q <= od_rd;
      od_err_q <= (wr_store || wr_discard) && (nv.busy || start_q);
      od_rdata_q <= '0;
      if (od_rd) begin
        if ((od_index == `PSC_IDX_STORE || od_index == `PSC_IDX_DISCARD) && od_sub == `PSC_SUB_COUNT) begin
          od_rdata_q <= {24'h00_0000, `PSC_SUB_ETH};
        end else if (od_index == `PSC_IDX_STORE && wr_slot != PSC_SLOT_NONE) begin
          od_rdata_q <= store_q[wr_slot];
        end else if (od_index == `PSC_IDX_DISCARD && wr_slot != PSC_SLOT_NONE) begin
          od_rdata_q <= discard_q[wr_slot];
        end else if (od_index == `PSC_IDX_MARKER && od_sub == `PSC_SUB_COUNT) begin
          od_rdata_q <= `PSC_MK_COUNT;
        end else if (od_index == `PSC_IDX_MARKER && od_sub == `PSC_SUB_MK_DATE) begin
          od_rdata_q <= mk_date_q;
        end else if (od_index == `PSC_IDX_MARKER && od_sub == `PSC_SUB_MK_TIME) begin
          od_rdata_q <= mk_time_q;
        end else begin
          od_err_q <= 1'b1;
        end
      end
    end
  end
endmodule : psc_top
`default_nettype wire

// File: testbench/psc_chk.sv
// Port assertions for the parameter store control
`default_nettype none
`include "psc_params.svh"
module psc_chk
  import psc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic od_wr, // Write strobe
  input wire logic od_rd, // Read strobe
  input wire logic [15:0] od_index, // Object index
  input wire logic [7:0] od_sub, // Subindex
  input wire logic [31:0] od_wdata, // Write value
  input wire logic od_rvalid_q, // Read answer
  input wire logic busy_q, // Operation running
  input wire logic restart_q, // Restart pulse
  input wire logic nv_req_q, // Memory request
  input wire psc_pkg::psc_op_t nv_op_q, // Memory operation
  input wire psc_pkg::psc_mask_t nv_mask_q, // Categories
  input wire logic nv_ack // Memory done
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic boot_wr = od_wr && od_index == `PSC_IDX_REBOOT && od_sub == 8'h01 && od_wdata == `PSC_KEY_REBOOT;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Only writes with a quiet cycle before them, so a start cycle never hides behind busy_q
  sequence cmd_wr(idx, sub, key);
    od_wr && od_index == idx && od_sub == sub && od_wdata == key && !busy_q && !$past(od_wr);
  endsequence
  sequence issued(op, msk);
    ##2 nv_req_q && nv_op_q == op && nv_mask_q == msk;
  endsequence
  save_all_a: assert property (cmd_wr(`PSC_IDX_STORE, 8'h01, `PSC_KEY_SAVE) |-> issued(PSC_OP_SAVE, 7'h5f))
    else $error("save-all not issued");
  discard_all_a: assert property (cmd_wr(`PSC_IDX_DISCARD, 8'h01, `PSC_KEY_DISCARD) |-> issued(PSC_OP_DISCARD, 7'h0f))
    else $error("discard-all mask wrong");
  wrong_key_a: assert property (od_wr && od_index == `PSC_IDX_STORE && od_wdata != `PSC_KEY_SAVE && !busy_q && !$past(od_wr) |-> ##2 !nv_req_q)
    else $error("wrong key started an operation");
  reboot_pulse_a: assert property (restart_q == $past(boot_wr))
    else $error("restart pulse wrong");
  read_answer_a: assert property (od_rd |=> od_rvalid_q)
    else $error("read not answered");
  req_hold_a: assert property (nv_req_q && !nv_ack |=> nv_req_q && $stable(nv_mask_q) && $stable(nv_op_q))
    else $error("request changed before ack");
  save_done_a: assert property (nv_req_q && nv_ack && nv_op_q == PSC_OP_SAVE |=> busy_q ##1 !busy_q)
    else $error("save completion timing wrong");
  load_busy_a: assert property (nv_req_q && nv_op_q == PSC_OP_LOAD |-> busy_q)
    else $error("reload without busy");
endmodule : psc_chk
bind psc_top psc_chk psc_chk_i (.clk(clk), .rst_n(rst_n), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
  .od_sub(od_sub), .od_wdata(od_wdata), .od_rvalid_q(od_rvalid_q), .busy_q(busy_q), .restart_q(restart_q),
  .nv_req_q(nv_req_q), .nv_op_q(nv_op_q), .nv_mask_q(nv_mask_q), .nv_ack(nv_ack));
`default_nettype wire

// File: testbench/psc_nv_model.sv
// Behavioural nonvolatile store answering the store engine
`default_nettype none
`include "psc_params.svh"
module psc_nv_model
  import psc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic nv_req_q, // Request
  input wire psc_pkg::psc_op_t nv_op_q, // Operation
  input wire psc_pkg::psc_mask_t nv_mask_q, // Categories
  input wire logic [31:0] nv_wdate_q, // Date to keep
  input wire logic [31:0] nv_wtime_q, // Time to keep
  output logic nv_ack, // Done pulse
  output logic [31:0] nv_rdate, // Loaded date
  output logic [31:0] nv_rtime, // Loaded time
  output logic [31:0] kept_date // Stored date
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic [31:0] kept_time;
  // Contents survive reset, as real nonvolatile memory does
  initial kept_date = 32'h0011_2233;
  initial kept_time = 32'h0044_5566;
  // Kept values come with ack; otherwise inverted so stale data is not trusted
  assign nv_rdate = nv_ack ? kept_date : ~kept_date;
  assign nv_rtime = nv_ack ? kept_time : ~kept_time;
  // Anything touching the comm category answers slowly, the rest at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      nv_ack <= 1'b0;
    end else begin
      nv_ack <= 1'b0;
      if (nv_req_q && !nv_ack) begin
        cnt <= cnt + 4'h1;
        if (cnt == (nv_mask_q[0] ? 4'hc : 4'h0)) begin
          cnt <= 4'h0;
          nv_ack <= 1'b1;
          // Marker kept only with its category
          if (nv_op_q == PSC_OP_SAVE && nv_mask_q[`PSC_CAT_MARK]) begin
            kept_date <= nv_wdate_q;
            kept_time <= nv_wtime_q;
          end
        end
      end
    end
  end
endmodule : psc_nv_model
`default_nettype wire

// File: testbench/parameter_store_control_tb.sv
// Self-checking bench for the parameter store control
`default_nettype none
`include "psc_params.svh"
module parameter_store_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, od_wr = 1'b0, od_rd = 1'b0, od_savable = 1'b0;
  logic [15:0] od_index = 16'h0;
  logic [7:0] od_sub = 8'h0;
  logic [31:0] od_wdata = 32'h0, od_rdata_q, nv_wdate_q, nv_wtime_q, nv_rdate, nv_rtime, kept_date;
  logic od_rvalid_q, od_err_q, busy_q, restart_q, nv_req_q, nv_ack;
  psc_op_t nv_op_q;
  psc_mask_t nv_mask_q;
  int err_total = 0, checked = 0;
  psc_top psc_top_i (.clk(clk), .rst_n(rst_n), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index), .od_sub(od_sub),
    .od_wdata(od_wdata), .od_savable(od_savable), .od_rdata_q(od_rdata_q), .od_rvalid_q(od_rvalid_q),
    .od_err_q(od_err_q), .busy_q(busy_q), .restart_q(restart_q), .nv_req_q(nv_req_q), .nv_op_q(nv_op_q),
    .nv_mask_q(nv_mask_q), .nv_wdate_q(nv_wdate_q), .nv_wtime_q(nv_wtime_q), .nv_ack(nv_ack),
    .nv_rdate(nv_rdate), .nv_rtime(nv_rtime));
  psc_nv_model psc_nv_model_i (.clk(clk), .rst_n(rst_n), .nv_req_q(nv_req_q), .nv_op_q(nv_op_q),
    .nv_mask_q(nv_mask_q), .nv_wdate_q(nv_wdate_q), .nv_wtime_q(nv_wtime_q), .nv_ack(nv_ack),
    .nv_rdate(nv_rdate), .nv_rtime(nv_rtime), .kept_date(kept_date));
  initial forever #2 clk = ~clk;
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic sv);
    @(posedge clk);
    od_wr <= 1'b1;
    od_index <= idx;
    od_sub <= sub;
    od_wdata <= d;
    od_savable <= sv;
    @(posedge clk);
    od_wr <= 1'b0;
    od_savable <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    @(posedge clk);
    od_rd <= 1'b1;
    od_index <= idx;
    od_sub <= sub;
    @(posedge clk);
    od_rd <= 1'b0;
    #1;
    chk({31'h0, od_rvalid_q}, 32'h1);
    chk(od_rdata_q, exp);
  endtask : rd
  task automatic idle;
    repeat (40) begin
      if (busy_q === 1'b0) break;
      @(posedge clk);
      #1;
    end
    chk({31'h0, busy_q}, 32'h0);
  endtask : idle
  // A zero mask means no operation may start
  task automatic cmd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] key, input psc_op_t op,
      input psc_mask_t m);
    wr(idx, sub, key, 1'b0);
    @(posedge clk);
    #1;
    chk({22'h0, nv_req_q, nv_req_q ? {nv_op_q, nv_mask_q} : 9'h0}, {22'h0, m != 7'h0, m != 7'h0 ? {op, m} : 9'h0});
    idle;
  endtask : cmd
  task automatic t_boot;
    idle;
    rd(`PSC_IDX_MARKER, `PSC_SUB_MK_DATE, 32'h0011_2233);
    rd(`PSC_IDX_STORE, `PSC_SUB_TUNE, `PSC_CMD_RST);
    rd(16'h1030, 8'h00, 32'h0);
    chk({31'h0, od_err_q}, 32'h1);
  endtask : t_boot
  task automatic t_cats;
    logic [7:0] subs [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0c};
    for (int i = 0; i < 6; i++) begin
      cmd(`PSC_IDX_STORE, subs[i], `PSC_KEY_SAVE, PSC_OP_SAVE, psc_mask_t'(7'h01 << i));
      cmd(`PSC_IDX_DISCARD, subs[i], `PSC_KEY_DISCARD, PSC_OP_DISCARD, psc_mask_t'(7'h01 << i));
    end
  endtask : t_cats
  task automatic t_marker;
    wr(`PSC_IDX_MARKER, `PSC_SUB_MK_DATE, 32'h2301_0203, 1'b0);
    wr(16'h6073, 8'h00, 32'h0000_0100, 1'b1);
    rd(`PSC_IDX_MARKER, `PSC_SUB_MK_DATE, 32'h0);
    wr(`PSC_IDX_MARKER, `PSC_SUB_MK_TIME, 32'h0000_1530, 1'b0);
    cmd(`PSC_IDX_STORE, `PSC_SUB_COMM, 32'h0, PSC_OP_SAVE, 7'h00);
    rd(`PSC_IDX_STORE, `PSC_SUB_COMM, `PSC_CMD_DONE);
    rd(`PSC_IDX_MARKER, `PSC_SUB_MK_TIME, 32'h0);
    cmd(`PSC_IDX_DISCARD, `PSC_SUB_TUNE, `PSC_KEY_SAVE, PSC_OP_DISCARD, 7'h00);
    wr(`PSC_IDX_REBOOT, `PSC_SUB_REBOOT, `PSC_KEY_SAVE, 1'b0);
    chk({31'h0, restart_q}, 32'h0);
    wr(`PSC_IDX_REBOOT, `PSC_SUB_REBOOT, `PSC_KEY_REBOOT, 1'b0);
    chk({31'h0, restart_q}, 32'h1);
  endtask : t_marker
  task automatic t_save_all;
    wr(`PSC_IDX_MARKER, `PSC_SUB_MK_DATE, 32'h2301_0203, 1'b0);
    wr(`PSC_IDX_MARKER, `PSC_SUB_MK_TIME, 32'h0000_1530, 1'b0);
    wr(`PSC_IDX_STORE, `PSC_SUB_ALL, `PSC_KEY_SAVE, 1'b0);
    wr(`PSC_IDX_DISCARD, `PSC_SUB_ALL, `PSC_KEY_DISCARD, 1'b0);
    chk({31'h0, od_err_q}, 32'h1);
    rd(`PSC_IDX_STORE, `PSC_SUB_ALL, `PSC_KEY_SAVE);
    idle;
    rd(`PSC_IDX_STORE, `PSC_SUB_ALL, `PSC_CMD_DONE);
    rd(`PSC_IDX_DISCARD, `PSC_SUB_ALL, `PSC_CMD_DONE);
    chk(kept_date, 32'h2301_0203);
    rd(`PSC_IDX_MARKER, `PSC_SUB_MK_TIME, 32'h0000_1530);
  endtask : t_save_all
  task automatic t_reload;
    cmd(`PSC_IDX_DISCARD, `PSC_SUB_ALL, `PSC_KEY_DISCARD, PSC_OP_DISCARD, 7'h0f);
    rd(`PSC_IDX_MARKER, `PSC_SUB_MK_DATE, 32'h2301_0203);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    idle;
    rd(`PSC_IDX_MARKER, `PSC_SUB_MK_DATE, 32'h2301_0203);
    rd(`PSC_IDX_MARKER, `PSC_SUB_MK_TIME, 32'h0000_1530);
  endtask : t_reload
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_boot;
    t_cats;
    t_marker;
    t_save_all;
    t_reload;
    close_out;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    close_out;
  end
endmodule : parameter_store_control_tb
`default_nettype wire
